// >>> verilog/cprs_pkg.sv
// Shared constants and types of the processor register set block.
// Assumes one processor clock and an APB master for software access.
`default_nettype none

package cprs_pkg;

    localparam int DATA_W    = 16;
    localparam int PADDR_W   = 20;
    localparam int SEG_SHIFT = 4;
    localparam int APB_AW    = 12;
    localparam int REG_COUNT = 12;

    // Word indices of the register bank, then of the two fetch offsets
    localparam logic [3:0] IDX_ACC  = 4'h0;
    localparam logic [3:0] IDX_CNT  = 4'h1;
    localparam logic [3:0] IDX_PORT = 4'h2;
    localparam logic [3:0] IDX_BASE = 4'h3;
    localparam logic [3:0] IDX_STK  = 4'h4;
    localparam logic [3:0] IDX_BPTR = 4'h5;
    localparam logic [3:0] IDX_SRC  = 4'h6;
    localparam logic [3:0] IDX_DST  = 4'h7;
    localparam logic [3:0] IDX_CODE = 4'h8;
    localparam logic [3:0] IDX_STKS = 4'h9;
    localparam logic [3:0] IDX_DAT0 = 4'hA;
    localparam logic [3:0] IDX_DAT1 = 4'hB;
    localparam logic [3:0] IDX_NIO  = 4'hC;
    localparam logic [3:0] IDX_FAO  = 4'hD;
    localparam logic [3:0] IDX_GPR_LAST = 4'h3;

    // APB byte offsets
    localparam logic [APB_AW-1:0] OFF_ACC  = 12'h000;
    localparam logic [APB_AW-1:0] OFF_CNT  = 12'h004;
    localparam logic [APB_AW-1:0] OFF_PORT = 12'h008;
    localparam logic [APB_AW-1:0] OFF_BASE = 12'h00C;
    localparam logic [APB_AW-1:0] OFF_STK  = 12'h010;
    localparam logic [APB_AW-1:0] OFF_BPTR = 12'h014;
    localparam logic [APB_AW-1:0] OFF_SRC  = 12'h018;
    localparam logic [APB_AW-1:0] OFF_DST  = 12'h01C;
    localparam logic [APB_AW-1:0] OFF_CODE = 12'h020;
    localparam logic [APB_AW-1:0] OFF_STKS = 12'h024;
    localparam logic [APB_AW-1:0] OFF_DAT0 = 12'h028;
    localparam logic [APB_AW-1:0] OFF_DAT1 = 12'h02C;
    localparam logic [APB_AW-1:0] OFF_NIO  = 12'h030;
    localparam logic [APB_AW-1:0] OFF_FAO  = 12'h034;

    localparam logic [DATA_W-1:0] WORD_RESET   = 16'h0000;
    localparam logic [DATA_W-1:0] OFFSET_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] OFFSET_STEP  = 16'h0001;

    typedef enum logic [1:0] {
        SEG_CODE  = 2'h0,
        SEG_STACK = 2'h1,
        SEG_DATA0 = 2'h2,
        SEG_DATA1 = 2'h3
    } cprs_seg_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK  = 2'b10
    } cprs_apb_st_t;

    // Pointer, index and segment words have no byte halves
    function automatic logic cprs_word_only(input logic [3:0] idx);
        cprs_word_only = (idx > IDX_GPR_LAST);
    endfunction

endpackage

`default_nettype wire

// >>> verilog/cprs_core_if.sv
// Internal carrier between the top, the register bank and the fetch pointers.
// Assumes all three parties run on the same processor clock.
`timescale 1ns/100ps
`default_nettype none

interface cprs_core_if;
    import cprs_pkg::*;

    logic                              apb_we;
    logic [3:0]                        apb_idx;
    logic [1:0]                        apb_be;
    logic [DATA_W-1:0]                 apb_wdata;
    logic                              eu_we;
    logic [3:0]                        eu_idx;
    logic [1:0]                        eu_be;
    logic [DATA_W-1:0]                 eu_wdata;
    logic [REG_COUNT-1:0][DATA_W-1:0]  words;
    logic                              take_byte;
    logic                              fetch_byte;
    logic                              branch;
    logic [DATA_W-1:0]                 branch_target;
    logic [DATA_W-1:0]                 next_instr_offset;
    logic [DATA_W-1:0]                 fetch_ahead_offset;

    modport top (
        output apb_we, apb_idx, apb_be, apb_wdata,
        output eu_we, eu_idx, eu_be, eu_wdata,
        output take_byte, fetch_byte, branch, branch_target,
        input  words, next_instr_offset, fetch_ahead_offset
    );
    modport bank (
        input  apb_we, apb_idx, apb_be, apb_wdata,
        input  eu_we, eu_idx, eu_be, eu_wdata,
        output words
    );
    modport fetch (
        input  take_byte, fetch_byte, branch, branch_target,
        output next_instr_offset, fetch_ahead_offset
    );
endinterface

`default_nettype wire

// >>> verilog/cprs_fetch_ptr.sv
// Next-instruction and fetch-ahead offset counters.
// Assumes take, fetch and branch strobes are one-cycle pulses on i_clk.
`timescale 1ns/100ps
`default_nettype none

module cprs_fetch_ptr (
    input wire logic  i_clk,
    input wire logic  i_reset_n,
    cprs_core_if.fetch bus
);
    import cprs_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] nio;
        logic [DATA_W-1:0] fao;
    } cprs_fetch_state_t;

    cprs_fetch_state_t state_ff;
    cprs_fetch_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (bus.branch) begin
            // Branch beats a same-cycle take or fetch
            nxt_state.nio = bus.branch_target;
            nxt_state.fao = bus.branch_target;
        end else begin
            if (bus.take_byte) begin
                nxt_state.nio = DATA_W'(state_ff.nio + OFFSET_STEP);
            end
            if (bus.fetch_byte) begin
                nxt_state.fao = DATA_W'(state_ff.fao + OFFSET_STEP);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= '{nio: OFFSET_RESET, fao: OFFSET_RESET};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign bus.next_instr_offset  = state_ff.nio;
    assign bus.fetch_ahead_offset = state_ff.fao;

    property p_branch_equal;
        @(posedge i_clk) disable iff (!i_reset_n)
        bus.branch |=> (state_ff.nio == state_ff.fao) && (state_ff.nio == $past(bus.branch_target));
    endproperty
    a_branch_equal: assert property (p_branch_equal) else $error("offsets differ after branch");

    property p_take_step;
        @(posedge i_clk) disable iff (!i_reset_n)
        (bus.take_byte && !bus.branch) |=> state_ff.nio == DATA_W'($past(state_ff.nio) + OFFSET_STEP);
    endproperty
    a_take_step: assert property (p_take_step) else $error("next offset did not step");

    property p_fetch_hold;
        @(posedge i_clk) disable iff (!i_reset_n)
        (!bus.fetch_byte && !bus.branch) |=> $stable(state_ff.fao);
    endproperty
    a_fetch_hold: assert property (p_fetch_hold) else $error("fetch offset moved unasked");

endmodule // cprs_fetch_ptr

`default_nettype wire

// >>> verilog/cprs_regbank.sv
// Word bank: general, pointer, index and segment registers with lane writes.
// Assumes the top resolves decode; execution writes win lanes they share with APB.
`timescale 1ns/100ps
`default_nettype none

module cprs_regbank (
    input wire logic  i_clk,
    input wire logic  i_reset_n,
    cprs_core_if.bank bus
);
    import cprs_pkg::*;

    typedef struct packed {
        logic [REG_COUNT-1:0][DATA_W-1:0] words;
    } cprs_bank_state_t;

    cprs_bank_state_t state_ff;
    cprs_bank_state_t nxt_state;
    logic [1:0]       eu_be_eff;

    always_comb begin
        nxt_state = state_ff;
        // Execution writes to word-only registers take a whole word whatever the lanes say
        eu_be_eff = cprs_word_only(bus.eu_idx) ? 2'b11 : bus.eu_be;
        for (int i = 0; i < REG_COUNT; i++) begin
            for (int b = 0; b < 2; b++) begin
                // Untouched lane keeps its byte
                if (bus.apb_we && bus.apb_idx == 4'(i) && bus.apb_be[b]) begin
                    nxt_state.words[i][b*8 +: 8] = bus.apb_wdata[b*8 +: 8];
                end
                if (bus.eu_we && bus.eu_idx == 4'(i) && eu_be_eff[b]) begin
                    nxt_state.words[i][b*8 +: 8] = bus.eu_wdata[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign bus.words = state_ff.words;

    // Helper capture for the lane checks
    logic             chk_arm_ff;
    logic             chk_word_ff;
    logic [3:0]       chk_idx_ff;
    logic [7:0]       chk_hi_ff;
    logic [DATA_W-1:0] chk_data_ff;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            chk_arm_ff  <= 1'b0;
            chk_word_ff <= 1'b0;
            chk_idx_ff  <= 4'h0;
            chk_hi_ff   <= 8'h00;
            chk_data_ff <= WORD_RESET;
        end else begin
            chk_arm_ff  <= bus.eu_we && bus.eu_be == 2'b01 && bus.eu_idx < 4'(REG_COUNT)
                           && !(bus.apb_we && bus.apb_idx == bus.eu_idx);
            chk_word_ff <= cprs_word_only(bus.eu_idx);
            chk_idx_ff  <= bus.eu_idx;
            chk_hi_ff   <= state_ff.words[bus.eu_idx][15:8];
            chk_data_ff <= bus.eu_wdata;
        end
    end

    property p_low_keeps_high;
        @(posedge i_clk) disable iff (!i_reset_n)
        (chk_arm_ff && !chk_word_ff) |-> state_ff.words[chk_idx_ff][15:8] == chk_hi_ff;
    endproperty
    a_low_keeps_high: assert property (p_low_keeps_high) else $error("high byte lost");

    property p_word_only_full;
        @(posedge i_clk) disable iff (!i_reset_n)
        (chk_arm_ff && chk_word_ff) |-> state_ff.words[chk_idx_ff] == chk_data_ff;
    endproperty
    a_word_only_full: assert property (p_word_only_full) else $error("word register split");

endmodule // cprs_regbank

`default_nettype wire

// >>> verilog/cprs_top.sv
// Processor register set: APB slave, segment address former, implicit operands.
// Assumes execution and fetch strobes come from logic on i_clk.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module cprs_top (
    input  wire logic                       i_clk,
    input  wire logic                       i_reset_n,
    input  wire logic                       i_psel,
    input  wire logic                       i_penable,
    input  wire logic                       i_pwrite,
    input  wire logic [cprs_pkg::APB_AW-1:0] i_paddr,
    input  wire logic [31:0]                i_pwdata,
    input  wire logic [3:0]                 i_pstrb,
    output logic                            o_pready,
    output logic [31:0]                     o_prdata,
    output logic                            o_pslverr,
    input  wire logic                       i_take_byte,
    input  wire logic                       i_fetch_byte,
    input  wire logic                       i_branch,
    input  wire logic [cprs_pkg::DATA_W-1:0] i_branch_target,
    input  wire logic                       i_gpr_we,
    input  wire logic [3:0]                 i_gpr_idx,
    input  wire logic [1:0]                 i_gpr_be,
    input  wire logic [cprs_pkg::DATA_W-1:0] i_gpr_wdata,
    input  wire cprs_pkg::cprs_seg_t        i_seg_sel,
    input  wire logic                       i_use_ea,
    input  wire logic [cprs_pkg::DATA_W-1:0] i_ea,
    output logic [cprs_pkg::DATA_W-1:0]     o_next_instr_offset,
    output logic [cprs_pkg::DATA_W-1:0]     o_fetch_ahead_offset,
    output logic [cprs_pkg::PADDR_W-1:0]    o_fetch_addr,
    output logic [cprs_pkg::PADDR_W-1:0]    o_phys_addr,
    output logic [cprs_pkg::DATA_W-1:0]     o_accumulator_word,
    output logic [cprs_pkg::DATA_W-1:0]     o_base_word,
    output logic [cprs_pkg::DATA_W-1:0]     o_count_word,
    output logic [cprs_pkg::DATA_W-1:0]     o_port_word,
    output logic [7:0]                      o_shift_count,
    output logic [cprs_pkg::DATA_W-1:0]     o_translate_addr,
    output logic [cprs_pkg::DATA_W-1:0]     o_io_port_addr
);
    import cprs_pkg::*;

    typedef struct packed {
        cprs_apb_st_t       fsm;
        logic               pready;
        logic [31:0]        prdata;
        logic               pslverr;
        logic [PADDR_W-1:0] phys_addr;
        logic [PADDR_W-1:0] fetch_addr;
        logic [DATA_W-1:0]  xlat;
    } cprs_top_state_t;

    cprs_top_state_t state_ff;
    cprs_top_state_t nxt_state;
    cprs_core_if     core ();

    logic [4:0]        dec;
    logic              dec_hit;
    logic [3:0]        dec_idx;
    logic              bad_write;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] seg_base;
    logic [DATA_W-1:0] seg_off;
    logic [DATA_W-1:0] pwdata_lo;

    // Hit flag and word index of an APB byte address
    function automatic logic [4:0] decode(input logic [APB_AW-1:0] a);
        case (a)
            OFF_ACC:  decode = {1'b1, IDX_ACC};
            OFF_CNT:  decode = {1'b1, IDX_CNT};
            OFF_PORT: decode = {1'b1, IDX_PORT};
            OFF_BASE: decode = {1'b1, IDX_BASE};
            OFF_STK:  decode = {1'b1, IDX_STK};
            OFF_BPTR: decode = {1'b1, IDX_BPTR};
            OFF_SRC:  decode = {1'b1, IDX_SRC};
            OFF_DST:  decode = {1'b1, IDX_DST};
            OFF_CODE: decode = {1'b1, IDX_CODE};
            OFF_STKS: decode = {1'b1, IDX_STKS};
            OFF_DAT0: decode = {1'b1, IDX_DAT0};
            OFF_DAT1: decode = {1'b1, IDX_DAT1};
            OFF_NIO:  decode = {1'b1, IDX_NIO};
            OFF_FAO:  decode = {1'b1, IDX_FAO};
            default:  decode = 5'h00;
        endcase
    endfunction

    // Segment base shifted four plus offset, wrapping at 1M
    function automatic logic [PADDR_W-1:0] phys(input logic [DATA_W-1:0] base,
                                                input logic [DATA_W-1:0] off);
        phys = {base, 4'h0} + {4'h0, off};
    endfunction

    // A partial lane write to a word-only register is refused, not split
    function automatic logic write_refused(input logic [4:0] d, input logic [3:0] strb);
        write_refused = !d[4] || d[3:0] >= IDX_NIO
                        || (cprs_word_only(d[3:0]) && (strb[1:0] == 2'b01 || strb[1:0] == 2'b10));
    endfunction

    assign dec       = decode(i_paddr);
    assign dec_hit   = dec[4];
    assign dec_idx   = dec[3:0];
    assign bad_write = write_refused(dec, i_pstrb);
    assign pwdata_lo = i_pwdata[15:0];

    always_comb begin
        rd_word = WORD_RESET;
        // Unmapped reads return zero, never the default decode slot
        if (!dec_hit) begin
            rd_word = WORD_RESET;
        end else if (dec_idx == IDX_NIO) begin
            rd_word = core.next_instr_offset;
        end else if (dec_idx == IDX_FAO) begin
            rd_word = core.fetch_ahead_offset;
        end else if (dec_idx < 4'(REG_COUNT)) begin
            rd_word = core.words[dec_idx];
        end
    end

    // Default offset per segment; the effective address overrides only where allowed
    always_comb begin
        seg_base = core.words[IDX_CODE];
        seg_off  = core.fetch_ahead_offset;
        case (i_seg_sel)
            SEG_CODE: begin
                seg_base = core.words[IDX_CODE];
                seg_off  = core.fetch_ahead_offset;
            end
            SEG_STACK: begin
                seg_base = core.words[IDX_STKS];
                seg_off  = i_use_ea ? i_ea : core.words[IDX_STK];
            end
            SEG_DATA0: begin
                seg_base = core.words[IDX_DAT0];
                seg_off  = i_use_ea ? i_ea : core.words[IDX_SRC];
            end
            SEG_DATA1: begin
                seg_base = core.words[IDX_DAT1];
                seg_off  = core.words[IDX_DST];
            end
            default: begin
                seg_base = core.words[IDX_CODE];
                seg_off  = core.fetch_ahead_offset;
            end
        endcase
    end

    always_comb begin
        nxt_state      = state_ff;
        core.apb_we    = 1'b0;
        core.apb_idx   = dec_idx;
        core.apb_be    = i_pstrb[1:0];
        core.apb_wdata = i_pwdata[15:0];
        case (state_ff.fsm)
            ST_IDLE: begin
                nxt_state.pready = 1'b0;
                if (i_psel && i_penable) begin
                    // One wait state: answer is prepared, then offered
                    nxt_state.pready  = 1'b1;
                    nxt_state.pslverr = i_pwrite ? bad_write : !dec_hit;
                    nxt_state.prdata  = i_pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
                    nxt_state.fsm     = ST_ACK;
                end
            end
            ST_ACK: begin
                // Write lands only at the edge the master sees pready
                core.apb_we      = i_psel && i_penable && i_pwrite && !state_ff.pslverr;
                nxt_state.pready = 1'b0;
                nxt_state.fsm    = ST_IDLE;
            end
            default: begin
                nxt_state.pready = 1'b0;
                nxt_state.fsm    = ST_IDLE;
            end
        endcase
        nxt_state.phys_addr  = phys(seg_base, seg_off);
        nxt_state.fetch_addr = phys(core.words[IDX_CODE], core.fetch_ahead_offset);
        nxt_state.xlat       = DATA_W'(core.words[IDX_BASE]
                                       + {8'h00, core.words[IDX_ACC][7:0]});
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= '{fsm: ST_IDLE, pready: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0,
                          phys_addr: 20'h00000, fetch_addr: 20'h00000, xlat: WORD_RESET};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign core.eu_we         = i_gpr_we;
    assign core.eu_idx        = i_gpr_idx;
    assign core.eu_be         = i_gpr_be;
    assign core.eu_wdata      = i_gpr_wdata;
    assign core.take_byte     = i_take_byte;
    assign core.fetch_byte    = i_fetch_byte;
    assign core.branch        = i_branch;
    assign core.branch_target = i_branch_target;

    cprs_regbank u_bank (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .bus       (core.bank)
    );

    cprs_fetch_ptr u_fetch (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .bus       (core.fetch)
    );

    assign o_pready             = state_ff.pready;
    assign o_prdata             = state_ff.prdata;
    assign o_pslverr            = state_ff.pslverr;
    assign o_next_instr_offset  = core.next_instr_offset;
    assign o_fetch_ahead_offset = core.fetch_ahead_offset;
    assign o_fetch_addr         = state_ff.fetch_addr;
    assign o_phys_addr          = state_ff.phys_addr;
    assign o_accumulator_word   = core.words[IDX_ACC];
    assign o_base_word          = core.words[IDX_BASE];
    assign o_count_word         = core.words[IDX_CNT];
    assign o_port_word          = core.words[IDX_PORT];
    assign o_shift_count        = core.words[IDX_CNT][7:0];
    assign o_translate_addr     = state_ff.xlat;
    assign o_io_port_addr       = core.words[IDX_PORT];

    sequence s_access_start;
        i_psel && i_penable && !o_pready;
    endsequence

    sequence s_bad_setup;
        (i_psel && !i_penable && !dec_hit) ##1 (i_psel && i_penable);
    endsequence

    property p_one_wait;
        @(posedge i_clk) disable iff (!i_reset_n)
        s_access_start |=> o_pready ##1 !o_pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("answer not after one wait");

    property p_unmapped_err;
        @(posedge i_clk) disable iff (!i_reset_n)
        s_bad_setup |=> o_pready && o_pslverr && o_prdata == 32'h0000_0000;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not flagged");

    property p_code_write;
        @(posedge i_clk) disable iff (!i_reset_n)
        (state_ff.fsm == ST_ACK && i_psel && i_penable && i_pwrite && !o_pslverr
         && dec_idx == IDX_CODE && i_pstrb[1:0] == 2'b11
         && !(i_gpr_we && i_gpr_idx == IDX_CODE))
        |=> core.words[IDX_CODE] == $past(pwdata_lo);
    endproperty
    a_code_write: assert property (p_code_write) else $error("code base write lost");

    property p_fetch_addr_form;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_branch && i_branch_target == 16'h0000) ##1 (!i_fetch_byte && !core.apb_we && !i_gpr_we)
        |=> o_fetch_addr == {$past(core.words[IDX_CODE]), 4'h0};
    endproperty
    a_fetch_addr_form: assert property (p_fetch_addr_form) else $error("fetch address wrong");

endmodule // cprs_top

`default_nettype wire

// >>> test/cprs_eu_model.sv
// Stand-in for the execution and fetch units: turns bench requests into strobes.
// Assumes requests are held for one cycle on the processor clock.
`timescale 1ns/100ps
`default_nettype none
module cprs_eu_model (
    input  wire logic        i_clk,
    input  wire logic [2:0]  i_req,
    input  wire logic [15:0] i_tgt,
    output logic             o_take,
    output logic             o_fetch,
    output logic             o_branch,
    output logic [15:0]      o_tgt
);
    always_ff @(posedge i_clk) begin
        o_take   <= i_req[0];
        o_fetch  <= i_req[1];
        o_branch <= i_req[2];
        // Junk outside a branch, so a stale target cannot pass
        o_tgt    <= i_req[2] ? i_tgt : ~o_tgt;
    end
endmodule // cprs_eu_model
`default_nettype wire

// >>> test/tb_cpu_register_set_and_fetch_pointers.sv
// Bench for the register set: APB master, fetch-unit stand-in, read scoreboard.
// Assumes the top answers APB after one wait state and registers its addresses.
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_register_set_and_fetch_pointers;
    import cprs_pkg::*;
    logic        i_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pw = 1'b0, use_ea = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pd = 32'h0, prd;
    logic [3:0]  ps = 4'h0;
    logic [2:0]  req = 3'h0;
    logic        gwe = 1'b0;
    logic [1:0]  gbe = 2'h0;
    logic [3:0]  gidx = 4'h0;
    logic [15:0] gwd = 16'h0;
    logic [15:0] tgt = 16'h0, ea = 16'h0, nio, fao, acc, bw, cw, dw, tra, iop, bt, c, t, v;
    logic [19:0] fa, pha;
    logic [7:0]  sc;
    logic        pr, slv, tk, fb, br;
    cprs_seg_t   seg = SEG_STACK;
    logic [31:0] exp_q[$];
    int          error_cnt = 0, cmp_count = 0, seed = 24545;
    always #2.5 i_clk = ~i_clk;
    cprs_eu_model u_cprs_eu_model (.i_clk(i_clk), .i_req(req), .i_tgt(tgt), .o_take(tk),
        .o_fetch(fb), .o_branch(br), .o_tgt(bt));
    cprs_top u_cprs_top (.i_clk(i_clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pd), .i_pstrb(ps), .o_pready(pr),
        .o_prdata(prd), .o_pslverr(slv), .i_take_byte(tk), .i_fetch_byte(fb),
        .i_branch(br), .i_branch_target(bt), .i_gpr_we(gwe), .i_gpr_idx(gidx),
        .i_gpr_be(gbe), .i_gpr_wdata(gwd), .i_seg_sel(seg), .i_use_ea(use_ea),
        .i_ea(ea), .o_next_instr_offset(nio), .o_fetch_ahead_offset(fao),
        .o_fetch_addr(fa), .o_phys_addr(pha), .o_accumulator_word(acc), .o_base_word(bw),
        .o_count_word(cw), .o_port_word(dw), .o_shift_count(sc), .o_translate_addr(tra),
        .o_io_port_addr(iop));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
             input logic e);
        psel <= 1'b1;
        pw   <= w;
        pa   <= a;
        pd   <= d;
        ps   <= s;
        @(posedge i_clk);
        pen <= 1'b1;
        do @(posedge i_clk); while (pr !== 1'b1);
        chk(slv, e);
        psel <= 1'b0;
        pen  <= 1'b0;
        // Idle edge so a following call never re-raises psel in this step
        @(posedge i_clk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x, input logic e);
        exp_q.push_back(x);
        apb(1'b0, a, 32'h0, 4'hF, e);
    endtask
    task ev(input logic [2:0] r, input logic [15:0] g);
        req <= r;
        tgt <= g;
        @(posedge i_clk);
    endtask
    task gw(input logic e, input logic [3:0] i, input logic [1:0] b, input logic [15:0] d);
        gwe  <= e;
        gidx <= i;
        gbe  <= b;
        gwd  <= d;
        @(posedge i_clk);
    endtask
    // Read data is judged against the oldest note when the answer shows
    always @(posedge i_clk)
        if (psel && pen && pr === 1'b1 && !pw && exp_q.size() > 0)
            chk(prd, exp_q.pop_front());
    initial begin
        #50000;
        error_cnt++;
        close_out;
    end
    initial begin
        repeat (12) @(posedge i_clk);
        rst_n <= 1'b1;
        @(posedge i_clk);
        use_ea <= 1'b1;
        rd(OFF_ACC, 32'h0, 1'b0);
        apb(1'b1, OFF_ACC, 32'h1234, 4'hF, 1'b0);
        apb(1'b1, OFF_ACC, 32'hCD77, 4'h2, 1'b0);
        rd(OFF_ACC, 32'hCD34, 1'b0);
        chk(acc, 32'hCD34);
        apb(1'b1, OFF_STK, 32'h5555, 4'h1, 1'b1);
        rd(OFF_STK, 32'h0, 1'b0);
        gw(1'b1, IDX_CNT, 2'h3, 16'hBEEF);
        gw(1'b1, IDX_CNT, 2'h1, 16'h0042);
        gw(1'b1, IDX_STK, 2'h1, 16'h9A5C);
        gw(1'b0, 4'h0, 2'h0, 16'h0);
        rd(OFF_CNT, 32'hBE42, 1'b0);
        rd(OFF_STK, 32'h9A5C, 1'b0);
        apb(1'b1, OFF_NIO, 32'h1, 4'hF, 1'b1);
        rd(12'h100, 32'h0, 1'b1);
        repeat (4) begin
            c = 16'($random(seed));
            t = 16'($random(seed));
            v = 16'($random(seed));
            apb(1'b1, OFF_CODE, {16'h0, c}, 4'hF, 1'b0);
            ev(3'h4, t);
            ev(3'h3, 16'h0);
            ev(3'h1, 16'h0);
            ev(3'h2, 16'h0);
            ev(3'h2, 16'h0);
            ev(3'h0, 16'h0);
            repeat (2) @(posedge i_clk);
            rd(OFF_NIO, {16'h0, t + 16'h2}, 1'b0);
            rd(OFF_FAO, {16'h0, t + 16'h3}, 1'b0);
            chk(fa, 20'({c, 4'h0} + {4'h0, t + 16'h3}));
            chk(nio, {16'h0, t + 16'h2});
            chk(fao, {16'h0, t + 16'h3});
            apb(1'b1, OFF_CNT, {16'h0, v}, 4'hF, 1'b0);
            apb(1'b1, OFF_PORT, {16'h0, ~v}, 4'hF, 1'b0);
            apb(1'b1, OFF_BASE, {16'h0, c}, 4'hF, 1'b0);
            apb(1'b1, OFF_STKS, {16'h0, t}, 4'hF, 1'b0);
            ea <= v;
            repeat (2) @(posedge i_clk);
            chk(cw, v);
            chk(sc, v[7:0]);
            chk(iop, 16'(~v));
            chk(dw, 16'(~v));
            chk(bw, c);
            chk(tra, 16'(c + 16'h0034));
            chk(pha, 20'({t, 4'h0} + {4'h0, v}));
            seg <= SEG_CODE;
            repeat (2) @(posedge i_clk);
            chk(pha, 20'({c, 4'h0} + {4'h0, t + 16'h3}));
            seg <= SEG_STACK;
        end
        ev(3'h4, 16'h0);
        ev(3'h0, 16'h0);
        repeat (3) @(posedge i_clk);
        chk(fa, {c, 4'h0});
        chk(nio, 32'h0);
        chk(fao, 32'h0);
        rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk(acc, 32'h0);
        chk(fa, 32'h0);
        rst_n <= 1'b1;
        rd(OFF_CODE, 32'h0, 1'b0);
        close_out;
    end
endmodule // tb_cpu_register_set_and_fetch_pointers
`default_nettype wire
